// >>> scd_top.sv
module scd_top
   import scd_pkg::*;
(
   input wire logic REF_CLK_IN, // Block clock, 250 MHz
   input wire logic RESETN_IN, // Async reset, active low
   input wire scd_pkg::scd_cfg_t CFG_IN, // Config word bits
   input wire scd_pkg::scd_req_t REQ_IN, // Register port request
   output logic [15:0] RDATA_OUT, // Read data, cycle after
   input wire logic [3:0] SRC_CLK_IN, // FAST_INTERNAL_RC, PRI, SEC, LOW_POWER_INTERNAL_RC
   input wire logic CLK_FAIL_IN, // Monitor failure pulse
   input wire logic IRQ_IN, // Any interrupt pulse
   output logic SYS_CLK_OUT, // Selected system clock
   output logic INSTR_CLK_OUT, // Instruction clock
   output logic CPU_EN_OUT, // CPU doze enable pulse
   output logic SECONDARY_OSCILLATOR_EN_OUT, // Secondary osc enable
   output logic PLL_EN_OUT, // PLL enable
   output logic [1:0] PRI_MODE_OUT, // Primary submode
   output logic FSM_EN_OUT, // Fail-safe monitor on
   output logic OSC2_O_OUT, // Pin two output value
   output logic OSC2_OE_OUT // Pin two drive enable
);
   import scd_pkg::*;

   // ****************************************************
   // Registers
   // ****************************************************
   scd_src_t cur_q, new_q;
   logic req_q, slock_q, plock_q, fail_q, secondary_oscillator_q;
   logic roi_q, raten_q;
   logic [2:0] ratio_q, psc_q;
   logic [1:0] unlk_h_q, unlk_l_q;
   scd_sw_t sw_q;
   logic [3:0] settle_q;
   logic [7:0] pll_cnt_q;
   logic [15:0] rdata_q;
   logic [7:0] psc_cnt_q;
   logic [6:0] doze_cnt_q;
   logic instr_q, cpu_en_q;
   logic sys_q;

   // ****************************************************
   // Decode
   // ****************************************************
   // Configuration drives permissions
   wire sw_allowed = ~CFG_IN.switch_monitor_cfg[1]; // RULE4
   wire fsm_on = (CFG_IN.switch_monitor_cfg == 2'b00); // RULE5
   wire wr_osc = REQ_IN.wr && (REQ_IN.addr == SCD_OSC_CTRL_OFS);
   wire wr_div = REQ_IN.wr && (REQ_IN.addr == SCD_CLK_DIV_OFS);
   wire [7:0] wh = REQ_IN.wdata[15:8];
   wire [7:0] wl = REQ_IN.wdata[7:0];
   wire key_h1 = wr_osc && (wh == SCD_KEY_H1);
   wire key_l1 = wr_osc && (wl == SCD_KEY_L1);
   // Unlocked byte writes; lock freezes selection
   wire frozen = slock_q && fsm_on; // RULE10
   wire hi_ok = wr_osc && unlk_h_q[1] && !frozen; // RULE23
   wire lo_ok = wr_osc && unlk_l_q[1]; // RULE23
   wire start_req = lo_ok && wl[SCD_REQ_POS] && sw_allowed
      && !frozen && (sw_q == SCD_SW_IDLE); // RULE22
   wire redundant = (new_q == cur_q); // RULE24
   wire new_pll = scd_uses_pll(new_q); // RULE19
   wire src_rdy = SRC_CLK_IN[sel_idx(new_q)];
   wire settle_done = (settle_q == SCD_SETTLE_CYC - 4'h1);
   wire commit = (sw_q == SCD_SW_SETTLE) && settle_done && src_rdy;
   wire fail_clr = lo_ok && !wl[SCD_FAIL_POS];
   wire irq_recover = IRQ_IN && roi_q; // RULE15

   // Source index into raw oscillator inputs
   function automatic logic [1:0] sel_idx(input scd_src_t s);
      unique case (s)
         SCD_SRC_PRI, SCD_SRC_PRIPLL: sel_idx = 2'h1;
         SCD_SRC_SEC: sel_idx = 2'h2;
         SCD_SRC_LOW_POWER_INTERNAL_RC: sel_idx = 2'h3;
         default: sel_idx = 2'h0;
      endcase
   endfunction : sel_idx

   // ****************************************************
   // Oscillator control register
   // ****************************************************
   // Power-on values caught from config one cycle after release
   logic boot_q;
   always_ff @(posedge REF_CLK_IN or negedge RESETN_IN) begin
      if (!RESETN_IN) begin
         boot_q <= 1'b1;
         cur_q <= SCD_SRC_FAST_RC_WITH_POSTSCALER; // RULE3
         new_q <= SCD_SRC_FAST_RC_WITH_POSTSCALER;
         req_q <= 1'b0;
         slock_q <= 1'b0;
         secondary_oscillator_q <= 1'b0;
         unlk_h_q <= 2'b00;
         unlk_l_q <= 2'b00;
      end else begin
         boot_q <= 1'b0;
         unlk_h_q <= {key_h1 ? 1'b0 : (unlk_h_q[0] && wr_osc
            && wh == SCD_KEY_H2), key_h1}; // RULE23
         unlk_l_q <= {key_l1 ? 1'b0 : (unlk_l_q[0] && wr_osc
            && wl == SCD_KEY_L2), key_l1}; // RULE23
         if (boot_q) begin
            cur_q <= CFG_IN.initial_source_cfg; // RULE2
            new_q <= CFG_IN.initial_source_cfg; // RULE8
         end else begin
            if (hi_ok && sw_allowed)
               new_q <= scd_src_t'(wh[2:0]); // RULE8
            if (commit)
               cur_q <= new_q; // RULE25
         end
         if (lo_ok) begin
            secondary_oscillator_q <= wl[SCD_SECONDARY_OSCILLATOR_POS]; // RULE14
            if (wl[SCD_SLOCK_POS])
               slock_q <= 1'b1; // RULE10
         end
         if (start_req)
            req_q <= 1'b1; // RULE9
         else if ((sw_q == SCD_SW_IDLE && req_q && redundant) || commit)
            req_q <= 1'b0; // RULE24
      end
   end

   // ****************************************************
   // Switch sequencer
   // ****************************************************
   // Settle counts edges seen while new source runs high
   always_ff @(posedge REF_CLK_IN or negedge RESETN_IN) begin
      if (!RESETN_IN) begin
         sw_q <= SCD_SW_IDLE;
         settle_q <= 4'h0;
      end else begin
         unique case (sw_q)
            SCD_SW_IDLE: begin
               settle_q <= 4'h0;
               if (req_q && !redundant)
                  sw_q <= new_pll ? SCD_SW_LOCKW : SCD_SW_SETTLE;
            end
            SCD_SW_LOCKW: begin
               if (plock_q)
                  sw_q <= SCD_SW_SETTLE;
            end
            SCD_SW_SETTLE: begin
               if (commit)
                  sw_q <= SCD_SW_IDLE;
               else if (src_rdy)
                  settle_q <= settle_q + 4'h1; // RULE25
            end
            default: sw_q <= SCD_SW_IDLE;
         endcase
      end
   end

   // ****************************************************
   // PLL lock and clock fail
   // ****************************************************
   // Lock asserted once start-up timer expires
   wire sw_valid = (sw_q == SCD_SW_IDLE) && req_q && !redundant;
   wire pll_on = scd_uses_pll(cur_q) || (sw_q != SCD_SW_IDLE
      && new_pll);
   always_ff @(posedge REF_CLK_IN or negedge RESETN_IN) begin
      if (!RESETN_IN) begin
         pll_cnt_q <= 8'h00;
         plock_q <= 1'b0;
         fail_q <= 1'b0;
      end else begin
         if (sw_valid || !pll_on) begin
            pll_cnt_q <= 8'h00; // RULE12
            plock_q <= 1'b0; // RULE12
         end else if (pll_cnt_q == SCD_PLL_LOCK_CYC) begin
            plock_q <= 1'b1; // RULE11
         end else begin
            pll_cnt_q <= pll_cnt_q + 8'h01;
         end
         // Set wins over a same-cycle clear
         if (CLK_FAIL_IN && fsm_on)
            fail_q <= 1'b1; // RULE13
         else if (fail_clr || sw_valid)
            fail_q <= 1'b0; // RULE13
      end
   end

   // ****************************************************
   // Clock divider register
   // ****************************************************
   always_ff @(posedge REF_CLK_IN or negedge RESETN_IN) begin
      if (!RESETN_IN) begin
         roi_q <= 1'b0;
         ratio_q <= 3'h0;
         raten_q <= 1'b0;
         psc_q <= SCD_PSC_RST; // RULE18
      end else begin
         if (wr_div) begin
            roi_q <= REQ_IN.wdata[SCD_ROI_POS];
            ratio_q <= REQ_IN.wdata[SCD_RATIO_POS +: 3];
            psc_q <= REQ_IN.wdata[SCD_PSC_POS +: 3];
         end
         // Interrupt recovery beats a same-cycle write
         if (irq_recover)
            raten_q <= 1'b0; // RULE15
         else if (wr_div)
            raten_q <= REQ_IN.wdata[SCD_RATEN_POS];
      end
   end

   // ****************************************************
   // Read port
   // ****************************************************
   // Reserved bits masked so they read zero
   wire [15:0] osc_img = {1'b0, cur_q, 1'b0, new_q, slock_q,
      1'b0, plock_q, 1'b0, fail_q, 1'b0, secondary_oscillator_q, req_q}; // RULE6
   wire [15:0] div_img = {roi_q, ratio_q, raten_q, psc_q, 8'h00};
   wire [15:0] rd_mux = (REQ_IN.addr == SCD_OSC_CTRL_OFS) ?
      (osc_img & SCD_OSC_CTRL_MASK) :
      (REQ_IN.addr == SCD_CLK_DIV_OFS) ?
      (div_img & SCD_CLK_DIV_MASK) : 16'h0000; // RULE20
   always_ff @(posedge REF_CLK_IN or negedge RESETN_IN) begin
      if (!RESETN_IN)
         rdata_q <= 16'h0000;
      else
         rdata_q <= REQ_IN.rd ? rd_mux : 16'h0000;
   end
   assign RDATA_OUT = rdata_q;

   // ****************************************************
   // Clock generation
   // ****************************************************
   // Sampled sources; postscaler as power-of-two tap
   wire raw_sel = SRC_CLK_IN[sel_idx(cur_q)];
   wire [3:0] psc_tap = (psc_q == 3'h7) ? 4'h8 : {1'b0, psc_q};
   wire [8:0] psc_ext = {psc_cnt_q, raw_sel};
   wire div_clk = (cur_q == SCD_SRC_FAST_RC_WITH_POSTSCALER) ?
      psc_ext[psc_tap] : raw_sel; // RULE18
   // In the commit cycle, clock updates only at a low phase; other cycles follow div_clk
   wire can_change = !sys_q && !div_clk; // RULE26
   logic fr_prev_q;
   always_ff @(posedge REF_CLK_IN or negedge RESETN_IN) begin
      if (!RESETN_IN) begin
         psc_cnt_q <= 8'h00;
         fr_prev_q <= 1'b0;
         sys_q <= 1'b0;
         instr_q <= 1'b0;
      end else begin
         fr_prev_q <= SRC_CLK_IN[0];
         if (SRC_CLK_IN[0] && !fr_prev_q)
            psc_cnt_q <= psc_cnt_q + 8'h01;
         if (!commit || can_change)
            sys_q <= div_clk; // RULE26
         if (div_clk && !sys_q)
            instr_q <= !instr_q; // RULE1
      end
   end

   // Doze: CPU runs one of 2^n peripheral cycles
   wire [6:0] doze_lim = (raten_q) ?
      7'((8'h01 << ratio_q) - 8'h01) : 7'h00; // RULE17
   wire instr_rise = div_clk && !sys_q && !instr_q;
   always_ff @(posedge REF_CLK_IN or negedge RESETN_IN) begin
      if (!RESETN_IN) begin
         doze_cnt_q <= 7'h00;
         cpu_en_q <= 1'b0;
      end else begin
         cpu_en_q <= instr_rise && (doze_cnt_q == 7'h00);
         if (instr_rise)
            doze_cnt_q <= (doze_cnt_q >= doze_lim) ? 7'h00 :
               doze_cnt_q + 7'h01; // RULE16
      end
   end

   // ****************************************************
   // Outputs
   // ****************************************************
   assign SYS_CLK_OUT = sys_q;
   assign INSTR_CLK_OUT = instr_q;
   assign CPU_EN_OUT = cpu_en_q;
   assign SECONDARY_OSCILLATOR_EN_OUT = secondary_oscillator_q; // RULE14
   assign PLL_EN_OUT = pll_on; // RULE19
   assign PRI_MODE_OUT = CFG_IN.primary_submode_cfg; // RULE7
   assign FSM_EN_OUT = fsm_on;
   // Pin two driven only in external clock submode
   assign OSC2_O_OUT = instr_q; // RULE21
   assign OSC2_OE_OUT = CFG_IN.osc_pin_function_cfg
      && (CFG_IN.primary_submode_cfg == SCD_SUB_EC); // RULE21

   // ****************************************************
   // Assertions
   // ****************************************************
   default clocking cb @(posedge REF_CLK_IN);
   endclocking
   default disable iff (!RESETN_IN);

   req_held_a: assert property (!sw_allowed && !boot_q |-> !req_q)
      else $error("request set while switching disabled"); // RULE22
   redund_clr_a: assert property (req_q && redundant &&
      sw_q == SCD_SW_IDLE && !start_req |=> !req_q)
      else $error("redundant request not cleared"); // RULE24
   commit_copy_a: assert property (commit |=> cur_q == $past(new_q)
      && !req_q) else $error("switch not completed"); // RULE25
   plock_clr_a: assert property (sw_valid |=> !plock_q)
      else $error("lock not cleared on switch"); // RULE12
   plock_nopll_a: assert property (!pll_on |=> !plock_q)
      else $error("lock set without PLL"); // RULE11
   fail_set_a: assert property (CLK_FAIL_IN && fsm_on |=> fail_q)
      else $error("clock fail not flagged"); // RULE13
   roi_clr_a: assert property (irq_recover |=> !raten_q)
      else $error("ratio enable not cleared"); // RULE15
   rsvd_zero_a: assert property (REQ_IN.rd |=>
      (RDATA_OUT & ~SCD_OSC_CTRL_MASK & ~SCD_CLK_DIV_MASK) == 0)
      else $error("reserved bit read nonzero"); // RULE20
   psc_rst_a: assert property (boot_q |-> psc_q == SCD_PSC_RST)
      else $error("postscaler reset wrong"); // RULE18

   switch_c: cover property (commit);
   redund_c: cover property (req_q && redundant);
   fail_c: cover property (fail_q);
   doze_c: cover property (raten_q && ratio_q == 3'h7 && cpu_en_q);
endmodule : scd_top

// >>> scd_pkg.sv
// Behaviour
// [RULE1] Instruction clock is selected clock halved
// [RULE2] Power-on source from submode and initial bits
// [RULE3] Unprogrammed configuration starts postscaled fast RC
// [RULE4] Switching allowed only when upper cfg bit zero
// [RULE5] Fail-safe monitor active only for cfg 00
// [RULE6] Three-bit source code; current source readable
// [RULE7] Submode selects crystal types or external clock
// [RULE8] New-source resets from initial cfg, names target
// [RULE9] Software sets request; hardware clears when done
// [RULE10] Set-only lock freezes selections when monitor on
// [RULE11] PLL lock reads one when locked or timed
// [RULE12] PLL lock cleared on switch or non-PLL mode
// [RULE13] Monitor failure sets fail flag; software clears
// [RULE14] Secondary enable bit turns oscillator on/off
// [RULE15] Recover-on-interrupt clears ratio enable
// [RULE16] Ratio code n gives one to 2^n
// [RULE17] Ratio enable off forces one to one
// [RULE18] Postscaler 1..64, then 256; resets to 8
// [RULE19] PLL times four, only primary or fast RC
// [RULE20] Unimplemented bits read zero, ignore writes
// [RULE21] Pin two shows instruction clock or I/O
// [RULE22] Switching disabled: request held zero
// [RULE23] Software unlocks bytes with key pairs first
// [RULE24] Same source request is aborted, request cleared
// [RULE25] Wait ten new-clock cycles, copy, clear request
// [RULE26] Changeover glitch-free on system clock
package scd_pkg;
   // ****************************************************
   // Register map
   // ****************************************************
   localparam logic [1:0] SCD_OSC_CTRL_OFS = 2'h0;
   localparam logic [1:0] SCD_CLK_DIV_OFS = 2'h1;
   localparam logic [15:0] SCD_OSC_CTRL_MASK = 16'h77AB;
   localparam logic [15:0] SCD_CLK_DIV_MASK = 16'hFF00;
   localparam int SCD_CUR_POS = 12;
   localparam int SCD_NEW_POS = 8;
   localparam int SCD_SLOCK_POS = 7;
   localparam int SCD_PLOCK_POS = 5;
   localparam int SCD_FAIL_POS = 3;
   localparam int SCD_SECONDARY_OSCILLATOR_POS = 1;
   localparam int SCD_REQ_POS = 0;
   localparam int SCD_ROI_POS = 15;
   localparam int SCD_RATIO_POS = 12;
   localparam int SCD_RATEN_POS = 11;
   localparam int SCD_PSC_POS = 8;
   localparam logic [2:0] SCD_PSC_RST = 3'h3;
   localparam logic [7:0] SCD_KEY_H1 = 8'h78;
   localparam logic [7:0] SCD_KEY_H2 = 8'h9A;
   localparam logic [7:0] SCD_KEY_L1 = 8'h46;
   localparam logic [7:0] SCD_KEY_L2 = 8'h57;
   localparam logic [3:0] SCD_SETTLE_CYC = 4'hA;
   localparam logic [7:0] SCD_PLL_LOCK_CYC = 8'h40;
   localparam logic [1:0] SCD_SUB_HS = 2'h2;
   localparam logic [1:0] SCD_SUB_XT = 2'h1;
   localparam logic [1:0] SCD_SUB_EC = 2'h0;

   typedef enum logic [2:0] {
      SCD_SRC_FRC = 3'b000,
      SCD_SRC_FAST_RC_WITH_MULTIPLIER = 3'b001,
      SCD_SRC_PRI = 3'b010,
      SCD_SRC_PRIPLL = 3'b011,
      SCD_SRC_SEC = 3'b100,
      SCD_SRC_LOW_POWER_INTERNAL_RC = 3'b101,
      SCD_SRC_RSVD = 3'b110,
      SCD_SRC_FAST_RC_WITH_POSTSCALER = 3'b111
   } scd_src_t;

   typedef enum logic [1:0] {
      SCD_SW_IDLE = 2'b00,
      SCD_SW_LOCKW = 2'b01,
      SCD_SW_SETTLE = 2'b10
   } scd_sw_t;

   // Nonvolatile configuration word subset
   typedef struct packed {
      logic osc_pin_function_cfg;
      scd_src_t initial_source_cfg;
      logic [1:0] switch_monitor_cfg;
      logic [1:0] primary_submode_cfg;
   } scd_cfg_t;

   // Register port request
   typedef struct packed {
      logic [1:0] addr;
      logic [15:0] wdata;
      logic wr;
      logic rd;
   } scd_req_t;

   // PLL only for primary and fast RC
   function automatic logic scd_uses_pll(input scd_src_t s);
      return (s == SCD_SRC_FAST_RC_WITH_MULTIPLIER) || (s == SCD_SRC_PRIPLL);
   endfunction : scd_uses_pll
endpackage : scd_pkg

// >>> scd_tb.sv
module tb;
   timeunit 1ns;
   timeprecision 100ps;
   import scd_pkg::*;
   // ****************************************************
   // Stimulus and design
   // ****************************************************
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   scd_cfg_t cfg;
   scd_req_t req = '0;
   logic [15:0] rdata;
   logic [3:0] src_clk = 4'h0;
   logic clk_fail = 1'b0;
   logic irq = 1'b0;
   logic sys_clk, instr_clk, cpu_en, secondary_oscillator_en, pll_en, fsm_en, osc2_o, osc2_oe;
   logic [1:0] pri_mode;
   int n_mismatch = 0;
   int checks_done = 0;
   int cyc = 0;
   // Behavioural register model
   int cur, nsrc, slock, plock, fail, secondary_oscillator;
   logic [15:0] v;
   int ns, ni, ps, pi;

   always #2 clk = ~clk;
   // Raw oscillators wander freely, so counts never line up by luck
   always @(posedge clk) src_clk <= 4'($urandom);

   scd_top dut_u (.REF_CLK_IN(clk), .RESETN_IN(rst_n), .CFG_IN(cfg),
      .REQ_IN(req), .RDATA_OUT(rdata), .SRC_CLK_IN(src_clk),
      .CLK_FAIL_IN(clk_fail), .IRQ_IN(irq), .SYS_CLK_OUT(sys_clk),
      .INSTR_CLK_OUT(instr_clk), .CPU_EN_OUT(cpu_en), .SECONDARY_OSCILLATOR_EN_OUT(secondary_oscillator_en),
      .PLL_EN_OUT(pll_en), .PRI_MODE_OUT(pri_mode), .FSM_EN_OUT(fsm_en),
      .OSC2_O_OUT(osc2_o), .OSC2_OE_OUT(osc2_oe));

   // ****************************************************
   // Bus and checking tasks
   // ****************************************************
   function automatic logic [15:0] osc_exp();
      return {1'b0, 3'(cur), 1'b0, 3'(nsrc), 1'(slock), 1'b0, 1'(plock),
         1'b0, 1'(fail), 1'b0, 1'(secondary_oscillator), 1'b0};
   endfunction : osc_exp

   task automatic summarize();
      $display("checks %0d mismatches %0d", checks_done, n_mismatch);
      if (n_mismatch == 0 && checks_done > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask : summarize

   // Hang guard, far above the few hundred cycles the tests need
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         n_mismatch++;
         summarize();
      end
   end

   task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
      checks_done++;
      if (g !== e) begin
         n_mismatch++;
         $display("[ERR] %s expected %h seen %h", nm, e, g);
      end
   endtask : chk

   // Entered just after an edge; request is taken at the next one
   task automatic bus(input logic [1:0] a, input logic [15:0] d, input logic w,
         input logic r);
      req <= '{a, d, w, r};
      @(posedge clk);
   endtask : bus

   task automatic idle();
      req <= '0;
      @(posedge clk);
   endtask : idle

   // Data is valid only in the cycle after the read strobe
   task automatic rchk(input logic [1:0] a, input logic [15:0] e, input string nm);
      bus(a, 16'h0000, 1'b0, 1'b1);
      req <= '0;
      #1 v = rdata;
      chk(nm, e, v);
      @(posedge clk);
   endtask : rchk

   // Key pairs must be back to back, target write straight after
   task automatic switch_to(input logic [2:0] s, input logic [7:0] lo);
      bus(2'h0, {SCD_KEY_H1, 8'h00}, 1'b1, 1'b0);
      bus(2'h0, {SCD_KEY_H2, 8'h00}, 1'b1, 1'b0);
      bus(2'h0, {5'h00, s, 8'h00}, 1'b1, 1'b0);
      bus(2'h0, {8'h00, SCD_KEY_L1}, 1'b1, 1'b0);
      bus(2'h0, {8'h00, SCD_KEY_L2}, 1'b1, 1'b0);
      bus(2'h0, {8'h00, lo}, 1'b1, 1'b0);
      idle();
   endtask : switch_to

   // Polls the request bit with a bound, then compares the whole word
   task automatic wait_req(input string nm);
      for (int i = 0; i < 100; i++) begin
         bus(2'h0, 16'h0000, 1'b0, 1'b1);
         req <= '0;
         #1 v = rdata;
         @(posedge clk);
         if (v[0] === 1'b0) break;
      end
      rchk(2'h0, osc_exp(), nm);
      $display("test %s done", nm);
   endtask : wait_req

   task automatic do_reset(input scd_cfg_t c);
      rst_n <= 1'b0;
      cfg <= c;
      repeat (6) @(posedge clk);
      rst_n <= 1'b1;
      repeat (2) @(posedge clk);
   endtask : do_reset

   // ****************************************************
   // Main sequence
   // ****************************************************
   initial begin
      void'($urandom(32'h6fcc));
      cfg = '{1'b0, SCD_SRC_FAST_RC_WITH_POSTSCALER, 2'b00, SCD_SUB_EC};
      do_reset('{1'b0, SCD_SRC_FAST_RC_WITH_POSTSCALER, 2'b00, SCD_SUB_EC});
      cur = 7; nsrc = 7; slock = 0; plock = 0; fail = 0; secondary_oscillator = 0;
      rchk(2'h0, osc_exp(), "osc reset");
      rchk(2'h1, 16'h0300, "div reset");
      rchk(2'h2, 16'h0000, "unmapped");
      chk("monitor on", 16'h0001, {15'h0, fsm_en});
      chk("submode", 16'h0000, {14'h0, pri_mode});
      // Write without keys must leave everything alone
      bus(2'h0, 16'h0283, 1'b1, 1'b0);
      idle();
      rchk(2'h0, osc_exp(), "locked write");
      $display("test reset done");
      repeat (4) begin
         v = 16'($urandom);
         bus(2'h1, v, 1'b1, 1'b0);
         rchk(2'h1, v & 16'hFF00, "div rand");
      end
      // Interrupt drops ratio enable only with recovery armed
      bus(2'h1, 16'hBB00, 1'b1, 1'b0);
      irq <= 1'b1;
      @(posedge clk);
      irq <= 1'b0;
      rchk(2'h1, 16'hB300, "roi set");
      bus(2'h1, 16'h3B00, 1'b1, 1'b0);
      irq <= 1'b1;
      @(posedge clk);
      irq <= 1'b0;
      rchk(2'h1, 16'h3B00, "roi clear");
      bus(2'h1, 16'h0000, 1'b1, 1'b0);
      idle();
      $display("test doze done");
      switch_to(SCD_SRC_FAST_RC_WITH_MULTIPLIER, 8'h01);
      cur = 1; nsrc = 1; plock = 1;
      wait_req("to pll");
      chk("pll on", 16'h0001, {15'h0, pll_en});
      switch_to(SCD_SRC_FAST_RC_WITH_MULTIPLIER, 8'h01);
      wait_req("redundant");
      switch_to(SCD_SRC_FRC, 8'h01);
      cur = 0; nsrc = 0; plock = 0;
      wait_req("to frc");
      chk("pll off", 16'h0000, {15'h0, pll_en});
      // Instruction clock rises once per two system clock rises
      ns = 0; ni = 0; ps = sys_clk; pi = instr_clk;
      repeat (200) begin
         @(posedge clk);
         #1;
         if (sys_clk && ps == 0) ns++;
         if (instr_clk && pi == 0) ni++;
         ps = sys_clk;
         pi = instr_clk;
      end
      chk("instr rate", 16'h0001,
         {15'h0, ns > 8 && (ni * 2 - ns) * (ni * 2 - ns) <= 4});
      clk_fail <= 1'b1;
      @(posedge clk);
      clk_fail <= 1'b0;
      fail = 1;
      rchk(2'h0, osc_exp(), "fail set");
      bus(2'h0, {8'h00, SCD_KEY_L1}, 1'b1, 1'b0);
      bus(2'h0, {8'h00, SCD_KEY_L2}, 1'b1, 1'b0);
      bus(2'h0, 16'h0082, 1'b1, 1'b0);
      idle();
      fail = 0; secondary_oscillator = 1; slock = 1;
      rchk(2'h0, osc_exp(), "fail clr lock");
      chk("sec enable", 16'h0001, {15'h0, secondary_oscillator_en});
      // Selection lock with monitor on freezes the source
      switch_to(SCD_SRC_SEC, 8'h83);
      repeat (60) @(posedge clk);
      bus(2'h0, 16'h0000, 1'b0, 1'b1);
      req <= '0;
      #1 chk("frozen src", 16'h0000, {13'h0, rdata[14:12]});
      @(posedge clk);
      $display("test switch done");
      do_reset('{1'b1, SCD_SRC_LOW_POWER_INTERNAL_RC, 2'b11, SCD_SUB_EC});
      cur = 5; nsrc = 5; slock = 0; fail = 0; secondary_oscillator = 0;
      rchk(2'h0, osc_exp(), "cfg source");
      chk("monitor off", 16'h0000, {15'h0, fsm_en});
      chk("pin drive", 16'h0001, {15'h0, osc2_oe});
      switch_to(SCD_SRC_FRC, 8'h01);
      rchk(2'h0, osc_exp(), "req held");
      $display("test no switch done");
      summarize();
   end
endmodule : tb
